/* hdl/eeprom_pin_port.sv */
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// RULE1 - Reader drives serial clock, else host bit1
// RULE2 - Sample clock pin at reset release
// RULE3 - Host reads data-out level at bit0
// RULE4 - Reader drives select in command, else bit2
// RULE5 - Reader drives data-in in command, else bit0
// RULE6 - EEPROM lines shared with three LED outputs
// RULE7 - Reset held at least thirty clocks
// RULE8 - Reader sends command, address, then clocks words
module eeprom_pin_port
    import eeprom_port_pkg::*;
(
    // Clock and reset
    input  wire logic                   REF_CLK,
    input  wire logic                   RESET_N,
    // Reader control and output
    input  wire logic                   READ_START,
    output logic                        READ_BUSY,
    output logic                        WORD_VALID,
    output logic [WORD_W-1:0]           WORD_DATA,
    output logic [ADDR_W-1:0]           WORD_ADDR,
    // Host access register
    input  wire logic [ACC_WIDTH-1:0]   ACC_WDATA,
    input  wire logic                   ACC_WE,
    output logic [ACC_WIDTH-1:0]        ACC_RDATA,
    output logic                        EEPROM_PRESENT_FLAG,
    // LED sources
    input  wire logic                   RECEIVE_ACTIVITY_LED,
    input  wire logic                   TRANSMIT_ACTIVITY_LED,
    input  wire logic                   LINK_STATUS_LED,
    input  wire logic                   LED_MODE,
    // Shared pins
    input  wire logic                   EEPROM_SERIAL_CLOCK_IN,
    output logic                        EEPROM_SERIAL_CLOCK_OUT,
    output logic                        EEPROM_SERIAL_CLOCK_OE,
    input  wire logic                   EEPROM_SERIAL_OUT_IN,
    output logic                        EEPROM_SERIAL_OUT_OUT,
    output logic                        EEPROM_SERIAL_OUT_OE,
    output logic                        EEPROM_CHIP_SELECT,
    output logic                        EEPROM_SERIAL_IN
);
    typedef enum logic [2:0] {ST_STRAP, ST_IDLE, ST_CMD, ST_DATA, ST_GAP} rd_state_t;

    typedef struct packed {
        rd_state_t              state;
        logic                   present;
        logic [ACC_WIDTH-1:0]   acc;
        logic                   sk;
        logic                   cs;
        logic                   di;
        logic [HALF_CNT_W-1:0]  half_cnt;
        logic [BIT_CNT_W-1:0]   bit_cnt;
        logic [WORD_CNT_W-1:0]  word_cnt;
        logic [CMD_W-1:0]       cmd_sh;
        logic [WORD_W-1:0]      data_sh;
        logic                   valid;
        logic [WORD_W-1:0]      word;
        logic [ADDR_W-1:0]      waddr;
    } port_state_t;

    port_state_t s_reg;
    port_state_t s_next;

    eeprom_sync_if dout_if();
    eeprom_sync_if skin_if();

    pin_sync u_dout_sync (
        .REF_CLK (REF_CLK),
        .RESET_N (RESET_N),
        .PIN     (EEPROM_SERIAL_OUT_IN),
        .sync    (dout_if)
    );

    pin_sync u_sk_sync (
        .REF_CLK (REF_CLK),
        .RESET_N (RESET_N),
        .PIN     (EEPROM_SERIAL_CLOCK_IN),
        .sync    (skin_if)
    );

    logic half_done;
    logic reading;
    assign half_done = (s_reg.half_cnt == HALF_CNT_W'(SK_HALF_CYC - 1));
    assign reading   = (s_reg.state == ST_CMD) || (s_reg.state == ST_DATA)
                     || (s_reg.state == ST_GAP);

    // Reader sequencer and host register
    always_comb begin
        s_next = s_reg;
        s_next.valid = 1'b0;
        if (ACC_WE) begin
            s_next.acc = ACC_WDATA;
        end
        unique case (s_reg.state)
            // Pin left undriven; wait for the synchroniser to fill with the strap level,
            // since its reset value would otherwise be taken for an absent memory
            ST_STRAP: begin
                s_next.half_cnt = s_reg.half_cnt + HALF_CNT_W'(1);
                if (s_reg.half_cnt == HALF_CNT_W'(SYNC_W + 1)) begin
                    s_next.present  = skin_if.level;  // [RULE2] [RULE7]
                    s_next.half_cnt = '0;
                    s_next.state    = ST_IDLE;
                end
            end
            ST_IDLE: begin
                s_next.sk = 1'b0;
                s_next.cs = 1'b0;
                s_next.di = 1'b0;
                if (READ_START && s_reg.present) begin
                    s_next.state    = ST_CMD;
                    s_next.cs       = 1'b1;
                    s_next.cmd_sh   = READ_CMD;
                    s_next.di       = READ_CMD[CMD_W-1];
                    s_next.bit_cnt  = '0;
                    s_next.word_cnt = '0;
                    s_next.half_cnt = '0;
                end
            end
            ST_CMD, ST_DATA: begin
                s_next.half_cnt = s_reg.half_cnt + HALF_CNT_W'(1);
                if (half_done) begin
                    s_next.half_cnt = '0;
                    s_next.sk       = ~s_reg.sk;
                    if (s_reg.sk) begin
                        // Falling edge: advance bit count and command bit
                        s_next.bit_cnt = s_reg.bit_cnt + BIT_CNT_W'(1);
                        if (s_reg.state == ST_CMD) begin
                            s_next.cmd_sh = {s_reg.cmd_sh[CMD_W-2:0], 1'b0};
                            s_next.di     = s_reg.cmd_sh[CMD_W-2];  // [RULE5] [RULE8]
                            if (s_reg.bit_cnt == BIT_CNT_W'(CMD_W - 1)) begin
                                s_next.state   = ST_DATA;
                                s_next.di      = 1'b0;
                                s_next.bit_cnt = '0;
                            end
                        end else if (s_reg.bit_cnt == BIT_CNT_W'(WORD_W - 1)) begin
                            s_next.bit_cnt  = '0;
                            s_next.valid    = 1'b1;
                            s_next.word     = s_reg.data_sh;
                            s_next.waddr    = s_reg.word_cnt[ADDR_W-1:0];
                            s_next.word_cnt = s_reg.word_cnt + WORD_CNT_W'(1);
                            if (s_reg.word_cnt == LAST_WORD) begin
                                s_next.state = ST_GAP;
                                s_next.cs    = 1'b0;  // [RULE4]
                            end
                        end
                    end else if (s_reg.state == ST_DATA) begin
                        // Rising edge: sample data-out
                        s_next.data_sh = {s_reg.data_sh[WORD_W-2:0], dout_if.level};  // [RULE8]
                    end
                end
            end
            ST_GAP: begin
                s_next.sk    = 1'b0;
                s_next.state = ST_IDLE;
            end
            default: s_next.state = ST_IDLE;
        endcase
    end

    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            s_reg       <= '0;
            s_reg.state <= ST_STRAP;
        end else begin
            s_reg <= s_next;
        end
    end

    // Reader owns clock, select and data-in while active, host bits or LEDs otherwise
    assign EEPROM_SERIAL_CLOCK_OUT = reading ? s_reg.sk
                                   : (LED_MODE ? RECEIVE_ACTIVITY_LED
                                      : s_reg.acc[ACC_CLOCK_BIT]);  // [RULE1] [RULE6]
    assign EEPROM_SERIAL_CLOCK_OE  = (s_reg.state != ST_STRAP);
    assign EEPROM_CHIP_SELECT      = reading ? s_reg.cs : s_reg.acc[ACC_SELECT_BIT];  // [RULE4]
    assign EEPROM_SERIAL_IN        = reading ? s_reg.di
                                   : (LED_MODE ? LINK_STATUS_LED
                                      : s_reg.acc[ACC_SERIAL_BIT]);  // [RULE5] [RULE6]
    // Data-out pin only drives LED when no reader or eeprom needs it
    assign EEPROM_SERIAL_OUT_OUT   = TRANSMIT_ACTIVITY_LED;  // [RULE6]
    assign EEPROM_SERIAL_OUT_OE    = LED_MODE && !reading && !s_reg.acc[ACC_SELECT_BIT];
    assign ACC_RDATA               = {s_reg.acc[ACC_SELECT_BIT], s_reg.acc[ACC_CLOCK_BIT],
                                      dout_if.level};  // [RULE3]
    assign EEPROM_PRESENT_FLAG     = s_reg.present;
    assign READ_BUSY               = reading;
    assign WORD_VALID              = s_reg.valid;
    assign WORD_DATA               = s_reg.word;
    assign WORD_ADDR               = s_reg.waddr;

    // Strap taken once the synchroniser holds the pin level
    property p_strap;
        @(posedge REF_CLK) disable iff (!RESET_N)
        (s_reg.state == ST_STRAP) && (s_reg.half_cnt == HALF_CNT_W'(SYNC_W + 1))
        |=> (EEPROM_PRESENT_FLAG == $past(skin_if.level));
    endproperty
    a_strap: assert property (p_strap) else $error("present flag not sampled");  // [RULE2]

    property p_clk_host;
        @(posedge REF_CLK) disable iff (!RESET_N)
        (!reading && !LED_MODE) |-> (EEPROM_SERIAL_CLOCK_OUT == s_reg.acc[ACC_CLOCK_BIT]);
    endproperty
    a_clk_host: assert property (p_clk_host) else $error("clock not host driven");  // [RULE1]

    property p_cs_read;
        @(posedge REF_CLK) disable iff (!RESET_N)
        ($rose(reading)) |-> EEPROM_CHIP_SELECT;
    endproperty
    a_cs_read: assert property (p_cs_read) else $error("select low at read start");  // [RULE4]

    property p_cs_host;
        @(posedge REF_CLK) disable iff (!RESET_N)
        (!reading) |-> (EEPROM_CHIP_SELECT == s_reg.acc[ACC_SELECT_BIT]);
    endproperty
    a_cs_host: assert property (p_cs_host) else $error("select not host driven");  // [RULE4]

    property p_di_host;
        @(posedge REF_CLK) disable iff (!RESET_N)
        (!reading && !LED_MODE) |-> (EEPROM_SERIAL_IN == s_reg.acc[ACC_SERIAL_BIT]);
    endproperty
    a_di_host: assert property (p_di_host) else $error("data-in not host driven");  // [RULE5]

    property p_dout_read;
        @(posedge REF_CLK) disable iff (!RESET_N)
        1'b1 |-> (ACC_RDATA[ACC_SERIAL_BIT] == dout_if.level);
    endproperty
    a_dout_read: assert property (p_dout_read) else $error("data-out not visible");  // [RULE3]

    property p_led_rx;
        @(posedge REF_CLK) disable iff (!RESET_N)
        (!reading && LED_MODE) |-> (EEPROM_SERIAL_CLOCK_OUT == RECEIVE_ACTIVITY_LED);
    endproperty
    a_led_rx: assert property (p_led_rx) else $error("receive led not routed");  // [RULE6]

    property p_start_bit;
        @(posedge REF_CLK) disable iff (!RESET_N)
        ($rose(reading)) |-> EEPROM_SERIAL_IN ##1 (s_reg.sk == 1'b0);
    endproperty
    a_start_bit: assert property (p_start_bit) else $error("no start bit");  // [RULE8]
endmodule : eeprom_pin_port
`default_nettype wire

/* hdl/eeprom_port_pkg.sv */
package eeprom_port_pkg;
    // Bit positions of the eeprom access register
    localparam int ACC_SERIAL_BIT = 0;
    localparam int ACC_CLOCK_BIT  = 1;
    localparam int ACC_SELECT_BIT = 2;
    localparam int ACC_WIDTH      = 3;
    // Serial clock timing
    localparam int CLK_PERIOD_NS  = 8;
    localparam int SK_HALF_NS     = 800;
    localparam int SK_HALF_CYC    = (SK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HALF_CNT_W     = 8;
    // Read command: start bit, opcode 10, address
    localparam int ADDR_W         = 6;
    localparam int CMD_W          = 3 + ADDR_W;
    localparam logic [CMD_W-1:0] READ_CMD = {3'h6, 6'h00};
    localparam int WORD_W         = 16;
    localparam int NUM_WORDS      = 64;
    localparam int BIT_CNT_W      = 5;
    localparam int WORD_CNT_W     = 7;
    localparam logic [WORD_CNT_W-1:0] LAST_WORD = 7'h3f;
    // Synchroniser depth
    localparam int SYNC_W         = 3;
endpackage : eeprom_port_pkg

/* hdl/eeprom_sync_if.sv */
`timescale 1ns/100ps
`default_nettype none
// Synchronised eeprom pin level passed from the synchroniser
interface eeprom_sync_if;
    logic level;
    modport src (output level);
    modport dst (input level);
endinterface : eeprom_sync_if
`default_nettype wire

/* hdl/pin_sync.sv */
`timescale 1ns/100ps
`default_nettype none
// Three-stage synchroniser; output changes once stages two and three agree
module pin_sync
    import eeprom_port_pkg::*;
(
    // Clock and reset
    input  wire logic         REF_CLK,
    input  wire logic         RESET_N,
    // Pin and result
    input  wire logic         PIN,
    eeprom_sync_if.src        sync
);
    typedef struct packed {
        logic [SYNC_W-1:0] stage;
        logic              level;
    } sync_state_t;

    sync_state_t st_reg;
    sync_state_t st_next;

    // Stage one feeds only stage two
    always_comb begin
        st_next = st_reg;
        st_next.stage = {st_reg.stage[SYNC_W-2:0], PIN};
        if (st_reg.stage[1] == st_reg.stage[2]) begin
            st_next.level = st_reg.stage[2];
        end
    end

    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign sync.level = st_reg.level;
endmodule : pin_sync
`default_nettype wire

/* tb/eeprom_chip_model.sv */
`timescale 1ns/100ps
`default_nettype none
// Serial memory stand-in: command on rising clock, then words in sequence
module eeprom_chip_model (
    // Pins
    input  wire logic sk,
    input  wire logic cs,
    input  wire logic di,
    output var  logic dout
);
    logic [8:0]  cmd;
    logic [5:0]  addr;
    logic [15:0] w;
    int          cnt;
    int          bitn;
    initial dout = 1'b1;
    // Released line shows the inverse, so a stale level never passes
    always @(negedge cs) begin
        cnt = 0;
        dout = ~dout;
    end
    // Shift command in, then present one data bit after each rise
    always @(posedge sk) begin
        if (cs) begin
            if (cnt < 9)
                cmd = {cmd[7:0], di};
            cnt = cnt + 1;
            if (cnt == 9 && cmd[8:6] == 3'h6) begin
                addr = cmd[5:0];
                bitn = 15;
            end else if (cnt > 9 && bitn == 0) begin
                bitn = 15;
                addr = addr + 6'h01;
            end else if (cnt > 9)
                bitn = bitn - 1;
            w = {10'h169, addr};
            if (cnt >= 9)
                dout = w[bitn];
        end
    end
endmodule : eeprom_chip_model
`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import eeprom_port_pkg::*;
    typedef struct packed {
        logic [2:0] wd;
        logic       lm;
        logic [2:0] led;
        logic [6:0] exp;
    } row_t;
    logic              ref_clk = 1'b0;
    logic              reset_n, read_start, acc_we, led_mode, strap;
    logic [2:0]        acc_wdata, acc_rdata, leds;
    logic              busy, wv, present, sk_out, sk_oe, do_out, do_oe, cs, di, chip_do;
    logic [WORD_W-1:0] wdata;
    logic [ADDR_W-1:0] waddr;
    logic [8:0]        cmd;
    logic [6:0]        pins;
    logic [15:0]       w;
    wire logic         sk_pin;
    wire logic         do_pin;
    int                fail_count = 0;
    int                compares = 0;
    int                n;
    // Rows: write, led mode, {rx,tx,link} -> {sk,cs,di,rd[2:1],oe,oe&out}
    row_t rows [8] = '{'{3'h0, 1'b0, 3'h0, 7'h00}, '{3'h1, 1'b0, 3'h0, 7'h10},
                       '{3'h2, 1'b0, 3'h7, 7'h44}, '{3'h4, 1'b0, 3'h0, 7'h28},
                       '{3'h7, 1'b0, 3'h0, 7'h7c}, '{3'h0, 1'b1, 3'h5, 7'h52},
                       '{3'h0, 1'b1, 3'h2, 7'h03}, '{3'h4, 1'b1, 3'h7, 7'h78}};
    // Pin levels: undriven clock pin rests at the strap resistor
    assign sk_pin = sk_oe ? sk_out : strap;
    assign do_pin = do_oe ? do_out : chip_do;
    always #4 ref_clk = ~ref_clk;
    eeprom_pin_port dut (.REF_CLK(ref_clk), .RESET_N(reset_n), .READ_START(read_start),
        .READ_BUSY(busy), .WORD_VALID(wv), .WORD_DATA(wdata), .WORD_ADDR(waddr),
        .ACC_WDATA(acc_wdata), .ACC_WE(acc_we), .ACC_RDATA(acc_rdata),
        .EEPROM_PRESENT_FLAG(present), .RECEIVE_ACTIVITY_LED(leds[2]),
        .TRANSMIT_ACTIVITY_LED(leds[1]), .LINK_STATUS_LED(leds[0]), .LED_MODE(led_mode),
        .EEPROM_SERIAL_CLOCK_IN(sk_pin), .EEPROM_SERIAL_CLOCK_OUT(sk_out),
        .EEPROM_SERIAL_CLOCK_OE(sk_oe), .EEPROM_SERIAL_OUT_IN(do_pin),
        .EEPROM_SERIAL_OUT_OUT(do_out), .EEPROM_SERIAL_OUT_OE(do_oe),
        .EEPROM_CHIP_SELECT(cs), .EEPROM_SERIAL_IN(di));
    eeprom_chip_model chip (.sk(sk_pin), .cs(cs), .di(di), .dout(chip_do));
    // Compare and count
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // Host write, then two more clocks for the pins to settle
    task automatic acc_write(input logic [2:0] v);
        @(negedge ref_clk);
        acc_wdata = v;
        acc_we = 1'b1;
        @(negedge ref_clk);
        acc_we = 1'b0;
        repeat (2) @(negedge ref_clk);
    endtask : acc_write
    task automatic do_reset(input logic pull);
        @(negedge ref_clk);
        strap = pull;
        reset_n = 1'b0;
        repeat (32) @(negedge ref_clk);
        reset_n = 1'b1;
        // Strap is taken only after the pin synchroniser has filled
        repeat (8) @(negedge ref_clk);
        check("present", present, pull);
        check("busy", busy, 16'h0);
        $display("test reset done");
    endtask : do_reset
    task automatic complete_run;
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : complete_run
    // Main sequence
    initial begin
        {reset_n, read_start, acc_we, led_mode, strap, acc_wdata, leds} = '0;
        do_reset(1'b0);
        // No memory strapped: start request is refused
        @(negedge ref_clk) read_start = 1'b1;
        @(negedge ref_clk) read_start = 1'b0;
        repeat (2) @(negedge ref_clk);
        check("busy", busy, 16'h0);
        foreach (rows[i]) begin
            led_mode = rows[i].lm;
            leds = rows[i].led;
            acc_write(rows[i].wd);
            pins = {sk_pin, cs, di, acc_rdata[2:1], do_oe, do_oe & do_out};
            check("pins", pins, rows[i].exp);
        end
        $display("test table done");
        led_mode = 1'b0;
        do_reset(1'b1);
        // Host bit-bangs a read of word 5 and samples the data line
        cmd = {3'h6, 6'h05};
        w = {10'h169, 6'h05};
        for (int i = 8; i >= 0; i--) begin
            acc_write({2'b10, cmd[i]});
            acc_write({2'b11, cmd[i]});
        end
        for (int i = 15; i >= 12; i--) begin
            acc_write(3'h4);
            check("host data", acc_rdata[0], w[i]);
            acc_write(3'h6);
        end
        acc_write(3'h0);
        $display("test host read done");
        // Automatic read; host writes meanwhile must not reach the pins
        @(negedge ref_clk) read_start = 1'b1;
        @(negedge ref_clk) read_start = 1'b0;
        check("busy", busy, 16'h1);
        acc_write(3'h0);
        check("reader pins", {sk_oe, cs}, 16'h3);
        for (int k = 0; k < 2; k++) begin
            n = 0;
            do begin
                @(posedge ref_clk);
                #1;
                n++;
            end while (wv !== 1'b1 && n < 8000);
            check("word", wdata, {10'h169, k[5:0]});
            check("addr", waddr, k[5:0]);
        end
        $display("test auto read done");
        // Third reset in the middle of a read
        do_reset(1'b1);
        complete_run();
    end
    // Watchdog
    initial begin
        #200000;
        fail_count++;
        $display("Error watchdog expected done seen timeout");
        complete_run();
    end
endmodule : tb_top
`default_nettype wire
